//--- hdl/ccd_readout_sequencer.sv
// Timing generator driving an interline sensor's vertical, horizontal, dump and reset gates.
// Assumes an external sampler that receives each pixel tag through the buffer and may stall.
`include "ccd_readout_params.svh"
`timescale 1ns/1ps
// Summary of operation
// - drop 12 leading, 13 trailing buffer pixels
// - dual mode reverses right register half
// - receiver reverses right rows, appends them
// - use centre dark columns only for black
// - horizontal A high, B low during vertical
// - wait resume delay after vertical pulse
// - dump gate high discards the line
// - no vertical or dump pulse during readout
// - barrier phases set each half's direction
// - single mode phase wiring to storage, barriers
// - single mode issues 4076 clocks per line
// - last phases follow horizontal phase A
// - dual mode wiring, 2040 clocks per line
// - right barriers inverted in-step, same edge
// - pulse reset gate after each sample
module ccd_readout_sequencer
	import ccd_readout_pkg::*;
#(
	parameter int V_PULSE_NS      = `V_PULSE_NS,
	parameter int RESUME_DELAY_NS = `RESUME_DELAY_NS,
	parameter int ROWS_PER_FRAME  = `TOP_DARK_ROWS + `PHOTO_ROWS + `BOTTOM_DARK_ROWS
)
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// Control
	input  wire logic        FRAME_START,
	input  wire logic        DUAL_MODE,
	input  wire logic        DUMP_LINE,
	output logic             BUSY,
	output logic             FRAME_DONE,
	// Vertical and dump gates
	output logic             VERTICAL_PHASE_A,
	output logic             VERTICAL_PHASE_B,
	output logic             LINE_DUMP_GATE,
	// Horizontal gates
	output logic             LEFT_STORAGE_A,
	output logic             LEFT_STORAGE_B,
	output logic             LEFT_BARRIER_A,
	output logic             LEFT_BARRIER_B,
	output logic             RIGHT_STORAGE_A,
	output logic             RIGHT_STORAGE_B,
	output logic             RIGHT_BARRIER_A,
	output logic             RIGHT_BARRIER_B,
	output logic             LEFT_LAST_PHASE,
	output logic             RIGHT_LAST_PHASE,
	output logic             LEFT_RESET_GATE,
	output logic             RIGHT_RESET_GATE,
	// Pixel tag stream to the sampler
	output logic             PIX_VALID,
	input  wire logic        PIX_READY,
	output logic [31:0]      PIX_TAG
);

	localparam int V_PULSE_CYC  = (V_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int RESUME_CYC   = (RESUME_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int V_PULSE_C1   = (V_PULSE_CYC < 1) ? 1 : V_PULSE_CYC;
	localparam int RESUME_C1    = (RESUME_CYC < 1) ? 1 : RESUME_CYC;

	seq_state_t  state_reg;
	seq_state_t  state_next;
	out_mode_t   mode_reg;
	logic        dump_reg;
	logic [15:0] wait_reg;
	logic [12:0] col_reg;
	logic [11:0] row_reg;
	logic [12:0] line_clks;
	logic        h_a_reg;
	logic        h_b_reg;
	logic        rba_reg;
	logic        rbb_reg;
	logic        last_a_reg;
	logic        dual_next;
	logic        v_reg;
	logic        reset_gate_reg;
	logic        busy_reg;
	logic        done_reg;
	pix_class_t  cls;
	logic        tag_valid;
	logic        tag_ready;
	logic [31:0] tag_data;
	logic        buf_valid;
	logic [31:0] buf_data;
	logic        pv_reg;
	logic [31:0] pt_reg;
	logic        last_col;
	logic        last_row;

	assign line_clks = (mode_reg == MODE_DUAL) ? 13'(`DUAL_LINE_CLKS) : 13'(`SINGLE_LINE_CLKS);
	assign last_col  = (col_reg == line_clks - 13'h1);
	assign last_row  = (row_reg == 12'(ROWS_PER_FRAME - 1));

	pixel_classifier u_class
	(
		.col  (col_reg),
		.mode (mode_reg),
		.cls  (cls)
	);

	// Tag: row, column, class, dual flag; one per sampled pixel.
	// column and dual flag let receiver reverse
	assign tag_valid = (state_reg == SEQ_HCLK_B);
	assign tag_data  = {row_reg, col_reg, 3'(cls), 3'h0, mode_reg == MODE_DUAL};

	pixel_skid_buffer #(.WIDTH(32), .DEPTH(2)) u_buf
	(
		.clk       (MCLK),
		.rst_n     (RST_N),
		.in_valid  (tag_valid),
		.in_ready  (tag_ready),
		.in_data   (tag_data),
		.out_valid (buf_valid),
		.out_ready (PIX_READY || !pv_reg),
		.out_data  (buf_data)
	);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			SEQ_IDLE:
				if (FRAME_START)
					state_next = SEQ_VPULSE;
			SEQ_VPULSE:
				if (wait_reg == 16'(V_PULSE_C1 - 1))
					state_next = SEQ_RESUME;
			SEQ_RESUME:
				if (wait_reg == 16'(RESUME_C1 - 1))
					state_next = SEQ_HCLK_A;
			SEQ_HCLK_A:
				state_next = SEQ_HCLK_B;
			SEQ_HCLK_B:
				// A stalled sampler holds the clock phase so no pixel is lost.
				if (tag_ready)
					state_next = last_col ? SEQ_NEXT_ROW : SEQ_HCLK_A;
			SEQ_NEXT_ROW:
				state_next = last_row ? SEQ_IDLE : SEQ_VPULSE;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			state_reg <= SEQ_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			mode_reg <= MODE_SINGLE;
		else if (state_reg == SEQ_IDLE && FRAME_START)
			mode_reg <= DUAL_MODE ? MODE_DUAL : MODE_SINGLE;
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			wait_reg <= '0;
		else if (state_next != state_reg)
			wait_reg <= '0;
		else
			wait_reg <= wait_reg + 16'h1;
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			col_reg <= '0;
			row_reg <= '0;
		end
		else
		begin
			if (state_reg == SEQ_IDLE)
				row_reg <= '0;
			else if (state_reg == SEQ_NEXT_ROW)
				row_reg <= row_reg + 12'h1;
			if (state_reg == SEQ_VPULSE)
				col_reg <= '0;
			else if (state_reg == SEQ_HCLK_B && tag_ready)
				col_reg <= col_reg + 13'h1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			v_reg <= 1'b0;
		else
			v_reg <= (state_next == SEQ_VPULSE);
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			dump_reg <= 1'b0;
		else if (state_reg != SEQ_VPULSE && state_next == SEQ_VPULSE)
			dump_reg <= DUMP_LINE;
		else if (state_next != SEQ_VPULSE)
			dump_reg <= 1'b0;
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			h_a_reg <= 1'b1;
		else
			h_a_reg <= (state_next != SEQ_HCLK_B);
	end

	// reset gate after sampling
	// The last pixel of a row is cleared as well, so no charge is left for the next row.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			reset_gate_reg <= 1'b0;
		else
			reset_gate_reg <= (state_reg == SEQ_HCLK_B) && tag_ready;
	end

	// phase B parked low
	// Phase B has its own flop so that every gate output comes straight from a register.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			h_b_reg <= 1'b0;
		else
			h_b_reg <= (state_next == SEQ_HCLK_B);
	end

	// The barrier flops follow the mode that holds after this edge, so a new frame's
	// wiring is in place together with its first vertical pulse.
	assign dual_next = (state_reg == SEQ_IDLE && FRAME_START) ? DUAL_MODE : (mode_reg == MODE_DUAL);

	// barriers switch with the other phases
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rba_reg <= 1'b0;
			rbb_reg <= 1'b1;
		end
		else
		begin
			rba_reg <= dual_next ? (state_next != SEQ_HCLK_B) : (state_next == SEQ_HCLK_B);
			rbb_reg <= dual_next ? (state_next == SEQ_HCLK_B) : (state_next != SEQ_HCLK_B);
		end
	end

	// last phases follow A
	// A separate flop keeps the last-phase load off the main phase A driver.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			last_a_reg <= 1'b1;
		else
			last_a_reg <= (state_next != SEQ_HCLK_B);
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			busy_reg <= (state_next != SEQ_IDLE);
			done_reg <= (state_reg == SEQ_NEXT_ROW) && last_row;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pv_reg <= 1'b0;
			pt_reg <= '0;
		end
		else if (PIX_READY || !pv_reg)
		begin
			pv_reg <= buf_valid;
			if (buf_valid)
				pt_reg <= buf_data;
		end
	end

	assign VERTICAL_PHASE_A = v_reg;
	assign VERTICAL_PHASE_B = v_reg;
	assign LINE_DUMP_GATE   = dump_reg;
	assign LEFT_STORAGE_A   = h_a_reg;
	assign LEFT_BARRIER_A   = h_a_reg;
	assign RIGHT_STORAGE_A  = h_a_reg;
	assign LEFT_STORAGE_B   = h_b_reg;
	assign LEFT_BARRIER_B   = h_b_reg;
	assign RIGHT_STORAGE_B  = h_b_reg;
	assign RIGHT_BARRIER_A  = rba_reg;
	assign RIGHT_BARRIER_B  = rbb_reg;
	assign LEFT_LAST_PHASE  = last_a_reg;
	assign RIGHT_LAST_PHASE = last_a_reg;
	assign LEFT_RESET_GATE  = reset_gate_reg;
	assign RIGHT_RESET_GATE = reset_gate_reg;
	assign BUSY             = busy_reg;
	assign FRAME_DONE       = done_reg;
	assign PIX_VALID        = pv_reg;
	assign PIX_TAG          = pt_reg;

endmodule

//--- hdl/ccd_readout_params.svh
// Timing and geometry constants for the sensor readout sequencer.
// Assumes inclusion by bare name from design files only.
`ifndef CCD_READOUT_PARAMS_SVH
`define CCD_READOUT_PARAMS_SVH

`define CLK_PERIOD_NS        100
`define TOP_DARK_ROWS        17
`define PHOTO_ROWS           2688
`define BOTTOM_DARK_ROWS     16
`define BUFFER_ROWS          8
`define EMPTY_PIX            4
`define LEFT_DARK_PIX        20
`define RIGHT_DARK_PIX       19
`define SINGLE_PHOTO_CLKS    4032
`define SINGLE_TRAIL_CLKS    20
`define DUAL_PHOTO_CLKS      2016
`define SINGLE_LINE_CLKS     4076
`define DUAL_LINE_CLKS       2040
`define BUF_PIX_START        12
`define BUF_PIX_END          13
`define SENSOR_PHOTO_PIX     4033
`define V_PULSE_NS           2000
`define RESUME_DELAY_NS      1000
`define RESET_GATE_NS        100

`endif

//--- hdl/ccd_readout_pkg.sv
// Types shared by the sensor readout sequencer modules.
// Assumes nothing of its surroundings.
package ccd_readout_pkg;

	typedef enum logic
	{
		MODE_SINGLE,
		MODE_DUAL
	} out_mode_t;

	typedef enum logic [2:0]
	{
		SEQ_IDLE,
		SEQ_VPULSE,
		SEQ_RESUME,
		SEQ_HCLK_A,
		SEQ_HCLK_B,
		SEQ_NEXT_ROW
	} seq_state_t;

	typedef enum logic [2:0]
	{
		PIX_EMPTY,
		PIX_DARK_LEFT,
		PIX_DARK_RIGHT,
		PIX_BUFFER,
		PIX_IMAGE,
		PIX_DARK_EDGE
	} pix_class_t;

endpackage

//--- hdl/pixel_skid_buffer.sv
// Two-entry valid/ready buffer holding one tagged pixel slot per entry.
// Assumes one clock; the reader may stall at any time.
`timescale 1ns/1ps
module pixel_skid_buffer
	import ccd_readout_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

//--- hdl/pixel_classifier.sv
// Combinational classifier of one horizontal clock position within a line.
// Assumes the column index counts from zero at the first empty pixel.
`include "ccd_readout_params.svh"
`timescale 1ns/1ps
module pixel_classifier
	import ccd_readout_pkg::*;
(
	// Position
	input  wire logic [12:0] col,
	input  wire out_mode_t   mode,
	// Class
	output pix_class_t       cls
);

	localparam logic [12:0] DARK_L_END = 13'(`EMPTY_PIX + `LEFT_DARK_PIX);
	localparam logic [12:0] PHOTO_END  = 13'(`EMPTY_PIX + `LEFT_DARK_PIX + `SENSOR_PHOTO_PIX);
	localparam logic [12:0] BUF_L_END  = 13'(`EMPTY_PIX + `LEFT_DARK_PIX + `BUF_PIX_START);
	localparam logic [12:0] BUF_R_BEG  = 13'(`EMPTY_PIX + `LEFT_DARK_PIX + `SENSOR_PHOTO_PIX - `BUF_PIX_END);
	localparam logic [12:0] DUAL_L_END = 13'(`DUAL_LINE_CLKS);

	always_comb
	begin
		cls = PIX_IMAGE;
		if (col < 13'(`EMPTY_PIX))
			cls = PIX_EMPTY;
		else if (col == 13'(`EMPTY_PIX) || col == DARK_L_END - 13'h1)
			cls = PIX_DARK_EDGE;
		else if (col < DARK_L_END)
			cls = PIX_DARK_LEFT;
		else if (col < BUF_L_END)
			cls = PIX_BUFFER;
		else if (mode == MODE_DUAL && col >= DUAL_L_END)
			cls = PIX_EMPTY;
		else if (mode == MODE_SINGLE && col >= BUF_R_BEG && col < PHOTO_END)
			cls = PIX_BUFFER;
		else if (mode == MODE_SINGLE && (col == PHOTO_END || col >= PHOTO_END + 13'(`RIGHT_DARK_PIX) - 13'h1))
			cls = PIX_DARK_EDGE;
		else if (mode == MODE_SINGLE && col > PHOTO_END)
			cls = PIX_DARK_RIGHT;
	end

endmodule

//--- bench/ccd_readout_sequencer_properties.sv
// Concurrent checks on the sequencer's gate outputs.
// Assumes one clock domain and a bind to every sequencer.
`timescale 1ns/1ps
module ccd_readout_sequencer_properties
#(
	parameter int V_PULSE_NS     = 2000,
	parameter int ROWS_PER_FRAME = 2721
)
(
	// Clock, reset, control
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic FRAME_START,
	input wire logic DUAL_MODE,
	input wire logic BUSY,
	input wire logic FRAME_DONE,
	// Gates
	input wire logic VERTICAL_PHASE_A,
	input wire logic VERTICAL_PHASE_B,
	input wire logic LINE_DUMP_GATE,
	input wire logic LEFT_STORAGE_A,
	input wire logic LEFT_STORAGE_B,
	input wire logic LEFT_BARRIER_A,
	input wire logic LEFT_BARRIER_B,
	input wire logic RIGHT_STORAGE_A,
	input wire logic RIGHT_STORAGE_B,
	input wire logic RIGHT_BARRIER_A,
	input wire logic RIGHT_BARRIER_B,
	input wire logic LEFT_LAST_PHASE,
	input wire logic RIGHT_LAST_PHASE,
	input wire logic LEFT_RESET_GATE,
	input wire logic RIGHT_RESET_GATE,
	// Stream
	input wire logic PIX_VALID,
	input wire logic PIX_READY
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	logic mode_reg;
	logic a_q;
	int   vcnt;
	int   hcnt;
	int   rcnt;
	always_ff @(posedge MCLK or negedge RST_N)
		if (!RST_N) mode_reg <= 1'b0;
		else if (FRAME_START && !BUSY) mode_reg <= DUAL_MODE;
	always_ff @(posedge MCLK or negedge RST_N)
		if (!RST_N) vcnt <= 0;
		else vcnt <= VERTICAL_PHASE_A ? vcnt + 1 : 0;
	// The clock count is judged at the next row's pulse or at frame end.
	always_ff @(posedge MCLK or negedge RST_N)
		if (!RST_N) {a_q, hcnt} <= {1'b1, 32'h0000_0000};
		else
		begin
			a_q <= LEFT_STORAGE_A;
			if ($rose(VERTICAL_PHASE_A) || FRAME_DONE) hcnt <= 0;
			else if (a_q && !LEFT_STORAGE_A) hcnt <= hcnt + 1;
		end
	always_ff @(posedge MCLK or negedge RST_N)
		if (!RST_N) rcnt <= 0;
		else if (FRAME_DONE) rcnt <= 0;
		else if ($rose(VERTICAL_PHASE_A)) rcnt <= rcnt + 1;
	chk_vert_pair: assert property (VERTICAL_PHASE_A == VERTICAL_PHASE_B)
		else $error("vertical phases differ");
	chk_vert_width: assert property ($fell(VERTICAL_PHASE_A) |-> vcnt == V_PULSE_NS / 100)
		else $error("vertical pulse width wrong");
	chk_vert_park: assert property (VERTICAL_PHASE_A |-> LEFT_STORAGE_A && !LEFT_STORAGE_B)
		else $error("horizontal clock not parked");
	chk_resume_wait: assert property ($fell(VERTICAL_PHASE_A) |->
		LEFT_STORAGE_A [*8] ##1 LEFT_STORAGE_A [*3] ##1 !LEFT_STORAGE_A)
		else $error("resume delay wrong");
	chk_dump_window: assert property (LINE_DUMP_GATE |-> VERTICAL_PHASE_A)
		else $error("dump gate outside transfer");
	chk_quiet_read: assert property (!LEFT_STORAGE_A |-> !VERTICAL_PHASE_A && !LINE_DUMP_GATE)
		else $error("gate pulsed during readout");
	chk_phase_wiring: assert property (BUSY |-> LEFT_BARRIER_A == LEFT_STORAGE_A
		&& RIGHT_STORAGE_A == LEFT_STORAGE_A && LEFT_STORAGE_B != LEFT_STORAGE_A
		&& LEFT_BARRIER_B != LEFT_STORAGE_A && RIGHT_STORAGE_B != LEFT_STORAGE_A
		&& RIGHT_BARRIER_A == (mode_reg ? LEFT_STORAGE_A : !LEFT_STORAGE_A)
		&& RIGHT_BARRIER_B != RIGHT_BARRIER_A)
		else $error("phase wiring wrong");
	chk_last_phase: assert property (LEFT_LAST_PHASE == LEFT_STORAGE_A && RIGHT_LAST_PHASE == LEFT_STORAGE_A)
		else $error("last phase differs");
	chk_reset_pulse: assert property (LEFT_RESET_GATE |->
		(RIGHT_RESET_GATE && LEFT_STORAGE_A && !$past(LEFT_STORAGE_A)) ##1 !LEFT_RESET_GATE)
		else $error("reset gate timing wrong");
	chk_line_count: assert property (($rose(VERTICAL_PHASE_A) || FRAME_DONE) && hcnt != 0 |->
		hcnt == (mode_reg ? 2040 : 4076))
		else $error("clocks per line wrong");
	chk_row_count: assert property (FRAME_DONE |-> rcnt == ROWS_PER_FRAME)
		else $error("rows per frame wrong");
	cover property ($rose(LINE_DUMP_GATE));
	cover property (FRAME_DONE && mode_reg);
	cover property (PIX_VALID && !PIX_READY && !LEFT_STORAGE_A);
endmodule
bind ccd_readout_sequencer ccd_readout_sequencer_properties #(.V_PULSE_NS(V_PULSE_NS),
	.ROWS_PER_FRAME(ROWS_PER_FRAME)) i_ccd_readout_sequencer_properties (.*);

//--- bench/sensor_model.sv
// Behavioural sensor: counts row transfers, dumped rows and clocks per line.
// Assumes gate levels straight from the sequencer on one clock.
`timescale 1ns/1ps
module sensor_model
(
	// Gates
	input wire logic clk,
	input wire logic v_a,
	input wire logic dump,
	input wire logic h_a,
	// Observations
	output int       line_clks,
	output int       rows_loaded,
	output int       rows_dumped
);
	logic v_q = 1'b0;
	logic h_q = 1'b1;
	logic dumping = 1'b0;
	int   hcnt = 0;
	initial {line_clks, rows_loaded, rows_dumped} = 96'h0;
	// each pulse moves one row; a high dump gate discards it.
	always @(posedge clk)
	begin
		v_q <= v_a;
		if (v_a && dump) dumping <= 1'b1;
		if (!v_a && v_q)
		begin
			rows_dumped <= rows_dumped + dumping;
			rows_loaded <= rows_loaded + !dumping;
			dumping <= 1'b0;
		end
	end
	// each phase A fall shifts one pixel out.
	always @(posedge clk)
	begin
		h_q <= h_a;
		if (v_a && !v_q && hcnt != 0) line_clks <= hcnt;
		if (v_a && !v_q) hcnt <= 0;
		else if (h_q && !h_a) hcnt <= hcnt + 1;
	end
endmodule

//--- bench/ccd_readout_sequencer_tb_top.sv
// Top testbench: stands in for the sampler and watches a sensor model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module ccd_readout_sequencer_tb_top
	import ccd_readout_pkg::*;
;
	logic MCLK, RST_N, FRAME_START, DUAL_MODE, DUMP_LINE, PIX_READY, BUSY, FRAME_DONE;
	logic VERTICAL_PHASE_A, VERTICAL_PHASE_B, LINE_DUMP_GATE, LEFT_STORAGE_A, LEFT_STORAGE_B;
	logic LEFT_BARRIER_A, LEFT_BARRIER_B, RIGHT_STORAGE_A, RIGHT_STORAGE_B, RIGHT_BARRIER_A;
	logic RIGHT_BARRIER_B, LEFT_LAST_PHASE, RIGHT_LAST_PHASE, LEFT_RESET_GATE, RIGHT_RESET_GATE;
	logic PIX_VALID, stall, hold;
	logic [31:0] PIX_TAG, last_tag;
	logic [12:0] prev_col;
	logic [2:0]  cls_of [0:4095];
	int failures, comparisons, ntags, seq_err, dones, rgates, cyc, line_clks, rows_loaded, rows_dumped;
	ccd_readout_sequencer #(.ROWS_PER_FRAME(3)) i_ccd_readout_sequencer (.MCLK, .RST_N,
		.FRAME_START, .DUAL_MODE, .DUMP_LINE, .BUSY, .FRAME_DONE, .VERTICAL_PHASE_A,
		.VERTICAL_PHASE_B, .LINE_DUMP_GATE, .LEFT_STORAGE_A, .LEFT_STORAGE_B, .LEFT_BARRIER_A,
		.LEFT_BARRIER_B, .RIGHT_STORAGE_A, .RIGHT_STORAGE_B, .RIGHT_BARRIER_A, .RIGHT_BARRIER_B,
		.LEFT_LAST_PHASE, .RIGHT_LAST_PHASE, .LEFT_RESET_GATE, .RIGHT_RESET_GATE, .PIX_VALID,
		.PIX_READY, .PIX_TAG);
	sensor_model i_sensor_model (.clk(MCLK), .v_a(VERTICAL_PHASE_A), .dump(LINE_DUMP_GATE),
		.h_a(LEFT_STORAGE_A), .line_clks, .rows_loaded, .rows_dumped);
	initial
	begin
		MCLK = 0;
		forever #50 MCLK = ~MCLK;
	end
	// The sampler drops ready three cycles in eight while stalling.
	always @(posedge MCLK)
	begin
		cyc++;
		#10 PIX_READY = !hold && (!stall || cyc % 8 > 2);
	end
	// Judged at the falling edge, where what the next rising edge takes has settled.
	always @(negedge MCLK)
	begin
		if (FRAME_DONE === 1'b1) dones++;
		if (LEFT_RESET_GATE === 1'b1) rgates++;
		if (PIX_VALID === 1'b1 && PIX_READY === 1'b1)
		begin
			ntags++;
			if (PIX_TAG[19:7] !== 13'h0000 && PIX_TAG[19:7] !== prev_col + 13'h0001) seq_err++;
			prev_col = PIX_TAG[19:7];
			cls_of[PIX_TAG[19:7]] = PIX_TAG[6:4];
			last_tag = PIX_TAG;
		end
	end
	task step(input int n);
		repeat (n) @(posedge MCLK);
		#10;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task start_frame(input logic dual);
		{ntags, seq_err, dones, rgates} = 0;
		DUAL_MODE = dual;
		FRAME_START = 1;
		step(1);
		FRAME_START = 0;
		step(1);
		check(BUSY, 1);
	endtask
	task wait_done();
		for (int i = 0; i < 40000 && FRAME_DONE !== 1'b1; i++) step(1);
		step(5);
		check(dones, 1);
		check(BUSY, 0);
	endtask
	task test_reset();
		check({VERTICAL_PHASE_A, LINE_DUMP_GATE, LEFT_STORAGE_A, LEFT_STORAGE_B}, 4'h2);
		check({RIGHT_BARRIER_A, RIGHT_BARRIER_B, BUSY, PIX_VALID}, 4'h4);
		$display("test_reset done");
	endtask
	task test_single();
		DUMP_LINE = 1;
		start_frame(0);
		check(LINE_DUMP_GATE, 1);
		step(25);
		DUMP_LINE = 0;
		wait_done();
		check(ntags, 3 * 4076);
		check(line_clks, 4076);
		check(rows_dumped, 1);
		check(rows_loaded, 2);
		check(rgates, 3 * 4076);
		check(seq_err, 0);
		check({cls_of[0], cls_of[3], cls_of[4], cls_of[5], cls_of[23]}, 15'o00515);
		check({cls_of[24], cls_of[35], cls_of[36], cls_of[4043], cls_of[4044]}, 15'o33443);
		check({cls_of[4058], last_tag[31:20], last_tag[0]}, {3'h2, 12'h002, 1'b0});
		$display("test_single done");
	endtask
	task test_dual_stall();
		stall = 1;
		start_frame(1);
		DUAL_MODE = 0;
		FRAME_START = 1;
		step(1);
		FRAME_START = 0;
		step(3000);
		hold = 1;
		step(40);
		// A full buffer must park the clock rather than lose a word.
		check({LEFT_STORAGE_A, PIX_VALID}, 2'h1);
		hold = 0;
		wait_done();
		stall = 0;
		check(ntags, 3 * 2040);
		check(line_clks, 2040);
		check(rgates, 3 * 2040);
		check(seq_err, 0);
		check({cls_of[0], cls_of[4], cls_of[5], cls_of[24], cls_of[36]}, 15'o05134);
		check(last_tag[0], 1);
		$display("test_dual_stall done");
	endtask
	task conclude();
		$display("Counts: comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		{RST_N, FRAME_START, DUAL_MODE, DUMP_LINE, stall, hold} = 0;
		{failures, comparisons, cyc} = 0;
		PIX_READY = 1;
		prev_col = 0;
		step(5);
		test_reset();
		step(15);
		RST_N = 1;
		step(1);
		test_single();
		test_dual_stall();
		conclude();
	end
	initial
	begin
		#7000000;
		failures++;
		conclude();
	end
endmodule
